// file: pkg/cfg_regs_pkg.sv
// Register map, field layout and reset values of the link configuration bank
// How it works
// R1: Reg peer_serializer_address holds peer address, reg own_address_and_write_protect own address set by cable-type input.
// R2: Write-protect bit makes registers peer_serializer_address to 0x1F read-only.
// R3: Pixel clock range: 00 low, 01 high, 11 auto, 10 forbidden.
// R4: Serial rate: 00 low, 01 high, 10 and 11 automatic detection.
// R5: Calibration interval: once, 2 ms, 16 ms or 256 ms periodic recalibration.
// R6: Sawtooth divider zero requests autocalibration, otherwise manual setting.
// R7: Bit 7 of reg link_status_and_channel_control mirrors the lock output, read-only, reset zero.
// R8: Reg link_status_and_channel_control bits 6,5,4 disable outputs, enable sequence test, sleep.
// R9: Interface type 00 two-wire, 01 UART when select input low, else disabled.
// R10: Reverse channel enable bit, default one.
// R11: Forward channel receive enable bit, default one.
// R12: Conversion method bit: zero sends register address, one command only.
// R13: Spread field: 00/10 none, 01 two percent, 11 four percent.
package cfg_regs_pkg;

    // ------------------------------------------------------------
    // Byte offsets
    // ------------------------------------------------------------
    localparam logic [7:0] OFS_PEER    = 8'h00;
    localparam logic [7:0] OFS_OWN     = 8'h04;
    localparam logic [7:0] OFS_RANGE   = 8'h08;
    localparam logic [7:0] OFS_CAL     = 8'h0C;
    localparam logic [7:0] OFS_STATUS  = 8'h10;
    localparam logic [7:0] OFS_CONV    = 8'h14;
    // Interrupt words sit above the protected window so write-one-to-clear still works
    localparam logic [7:0] OFS_IRQ_ST  = 8'h80;
    localparam logic [7:0] OFS_IRQ_MSK = 8'h84;
    localparam logic [7:0] OFS_PROT_HI = 8'h7C;   // Last protected word (index 0x1F)

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [6:0] RST_PEER_ADDR = 7'h40;   // 1000000
    localparam logic [6:0] RST_OWN_COAX  = 7'h48;   // 1001000
    localparam logic [6:0] RST_OWN_PAIR  = 7'h49;   // 1001001
    localparam logic [7:0] RST_RANGE     = 8'h1F;   // Spread 00, rsvd 01, 11, 11
    localparam logic [7:0] RST_CAL       = 8'h00;
    localparam logic [6:0] RST_CTRL      = 7'h07;   // Bits 6:0 of the status register
    localparam logic [7:0] RST_CONV      = 8'h00;

    // ------------------------------------------------------------
    // Timing: strap settling and calibration periods
    // ------------------------------------------------------------
    localparam logic [1:0] STRAP_SETTLE = 2'h2;   // Edges before the strap is trusted
    localparam int CLK_MHZ      = 200;
    localparam int CAL_MS_0     = 2;
    localparam int CAL_MS_1     = 16;
    localparam int CAL_MS_2     = 256;
    localparam int CAL_CYC_0    = CAL_MS_0 * CLK_MHZ * 1000;
    localparam int CAL_CYC_1    = CAL_MS_1 * CLK_MHZ * 1000;
    localparam int CAL_CYC_2    = CAL_MS_2 * CLK_MHZ * 1000;

    // ------------------------------------------------------------
    // Encodings
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        RATE_LOW  = 2'b00,
        RATE_HIGH = 2'b01,
        RATE_AUTO = 2'b11
    } rate_sel_e;

    typedef enum logic [1:0] {
        SPREAD_NONE = 2'b00,
        SPREAD_2PC  = 2'b01,
        SPREAD_4PC  = 2'b11
    } spread_sel_e;

endpackage

// file: hdl/deserializer_config_registers.sv
// APB register bank holding link, spread, channel and lock configuration
`timescale 1ns/1ps
`default_nettype none
module deserializer_config_registers
    import cfg_regs_pkg::*;
#(
    parameter int CAL_PERIOD_0 = CAL_CYC_0,
    parameter int CAL_PERIOD_1 = CAL_CYC_1,
    parameter int CAL_PERIOD_2 = CAL_CYC_2
) (
    // Clock and reset
    input  wire logic        pclk,
    input  wire logic        presetn,
    // APB slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // Device pins
    input  wire logic        cable_type_input,
    input  wire logic        interface_select_input,
    input  wire logic        lock_pin,
    // Configuration outputs
    output logic      [6:0]  peer_serializer_address,
    output logic      [6:0]  own_device_address,
    output logic             register_write_protect,
    output logic      [1:0]  spread_sel,
    output logic      [1:0]  pixel_clock_range,
    output logic             pixel_range_auto,
    output logic      [1:0]  serial_rate_range,
    output logic             serial_rate_auto,
    output logic      [1:0]  modulation_calibration_interval,
    output logic      [4:0]  sawtooth_divider,
    output logic             divider_autocal,
    output logic             calibrate_pulse,
    output logic             output_disable,
    output logic             bit_sequence_test_enable,
    output logic             sleep_mode,
    output logic             local_i2c_enable,
    output logic             local_uart_enable,
    output logic             reverse_channel_enable,
    output logic             forward_channel_enable,
    output logic             conversion_method,
    // Interrupt
    output logic             irq
);

    // ------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------
    logic [7:0]  peer_r, own_r, range_r, cal_r, conv_r;
    logic [6:0]  ctrl_r;
    logic [1:0]  irq_st_r, irq_st_nxt, irq_msk_r;
    logic        own_loaded_r;
    logic [1:0]  strap_cnt_r;
    logic        lock_s1_r, lock_s2_r, lock_d_r;
    logic        cable_s1_r, cable_s2_r;
    logic        isel_s1_r, isel_s2_r;
    logic [27:0] cal_cnt_r;
    logic        cal_once_r;
    logic [31:0] prdata_r;

    // ------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------
    wire logic access    = psel & penable;
    wire logic wr_req    = access & pwrite;
    wire logic rd_req    = access & ~pwrite;
    wire logic hit_peer  = (paddr == OFS_PEER);
    wire logic hit_own   = (paddr == OFS_OWN);
    wire logic hit_range = (paddr == OFS_RANGE);
    wire logic hit_cal   = (paddr == OFS_CAL);
    wire logic hit_stat  = (paddr == OFS_STATUS);
    wire logic hit_conv  = (paddr == OFS_CONV);
    wire logic hit_ist   = (paddr == OFS_IRQ_ST);
    wire logic hit_imsk  = (paddr == OFS_IRQ_MSK);
    wire logic mapped    = hit_peer | hit_own | hit_range | hit_cal | hit_stat
                         | hit_conv | hit_ist | hit_imsk;
    // Protected window covers all words up to index 0x1F, mapped or not
    wire logic in_prot   = (paddr <= OFS_PROT_HI) && (paddr[1:0] == 2'b00);
    wire logic blocked   = register_write_protect & in_prot;             // R2
    wire logic wr_ok     = wr_req & pstrb[0] & ~blocked;                 // R2
    wire logic [7:0] wb  = pwdata[7:0];

    // Zero-wait slave; unmapped addresses or protected writes flag an error
    assign pready  = 1'b1;
    assign pslverr = access & (~mapped | (pwrite & blocked));

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lock_s1_r  <= 1'b0;
            lock_s2_r  <= 1'b0;
            lock_d_r   <= 1'b0;
            cable_s1_r <= 1'b0;
            cable_s2_r <= 1'b0;
            isel_s1_r  <= 1'b0;
            isel_s2_r  <= 1'b0;
        end else begin
            lock_s1_r  <= lock_pin;
            lock_s2_r  <= lock_s1_r;
            lock_d_r   <= lock_s2_r;
            cable_s1_r <= cable_type_input;
            cable_s2_r <= cable_s1_r;
            isel_s1_r  <= interface_select_input;
            isel_s2_r  <= isel_s1_r;
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    // Own address is strapped from the cable-type input once the synchroniser
    // has filled after reset, so the async reset only loads constants.
    // A software write before that point wins and cancels the strap load.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peer_r       <= {RST_PEER_ADDR, 1'b0};                       // R1
            own_r        <= {RST_OWN_COAX, 1'b0};
            own_loaded_r <= 1'b0;
            strap_cnt_r  <= 2'h0;
            range_r      <= RST_RANGE;
            cal_r        <= RST_CAL;
            ctrl_r       <= RST_CTRL;                                    // R8
            conv_r       <= RST_CONV;
        end else begin
            if (strap_cnt_r != STRAP_SETTLE) strap_cnt_r <= strap_cnt_r + 2'h1;
            if (wr_ok && hit_own) begin
                own_loaded_r <= 1'b1;
                own_r        <= wb;                                      // R2
            end else if (!own_loaded_r && strap_cnt_r == STRAP_SETTLE) begin
                own_loaded_r <= 1'b1;
                own_r        <= {cable_s2_r ? RST_OWN_PAIR : RST_OWN_COAX, 1'b0}; // R1
            end
            if (wr_ok && hit_peer)  peer_r  <= {wb[7:1], 1'b0};          // R1
            if (wr_ok && hit_range) range_r <= {wb[7:6], 2'b01, wb[3:0]};
            if (wr_ok && hit_cal)   cal_r   <= {wb[7:6], 1'b0, wb[4:0]};
            if (wr_ok && hit_stat)  ctrl_r  <= wb[6:0];                  // R8
            if (wr_ok && hit_conv)  conv_r  <= {wb[7], 7'h00};           // R12
        end
    end

    // ------------------------------------------------------------
    // Decoded controls
    // ------------------------------------------------------------
    assign peer_serializer_address  = peer_r[7:1];                       // R1
    assign own_device_address       = own_r[7:1];                        // R1
    assign register_write_protect   = own_r[0];                          // R2
    // Code 10 maps to no spread, same as 00
    assign spread_sel = (range_r[7:6] == SPREAD_2PC) ? SPREAD_2PC :
                        (range_r[7:6] == SPREAD_4PC) ? SPREAD_4PC : SPREAD_NONE; // R13
    // Forbidden 10 falls back to automatic detection
    assign pixel_clock_range = range_r[3:2];                             // R3
    assign pixel_range_auto  = range_r[3];                               // R3
    assign serial_rate_range = range_r[1:0];                             // R4
    assign serial_rate_auto  = range_r[1];                               // R4
    assign modulation_calibration_interval = cal_r[7:6];                 // R5
    assign sawtooth_divider  = cal_r[4:0];                               // R6
    assign divider_autocal   = (cal_r[4:0] == 5'b00000);                 // R6
    assign output_disable           = ctrl_r[6];                         // R8
    assign bit_sequence_test_enable = ctrl_r[5];                         // R8
    assign sleep_mode               = ctrl_r[4];                         // R8
    assign local_i2c_enable  = ~isel_s2_r & (ctrl_r[3:2] == 2'b00);      // R9
    assign local_uart_enable = ~isel_s2_r & (ctrl_r[3:2] == 2'b01);      // R9
    assign reverse_channel_enable = ctrl_r[1];                           // R10
    assign forward_channel_enable = ctrl_r[0];                           // R11
    assign conversion_method      = conv_r[7];                           // R12

    // ------------------------------------------------------------
    // Spread-modulation calibration scheduler
    // ------------------------------------------------------------
    // One pulse right after lock; afterwards periodic pulses if selected.
    wire logic [27:0] cal_limit =
        (cal_r[7:6] == 2'b01) ? 28'(CAL_PERIOD_0 - 1) :
        (cal_r[7:6] == 2'b10) ? 28'(CAL_PERIOD_1 - 1) : 28'(CAL_PERIOD_2 - 1);
    wire logic periodic = (cal_r[7:6] != 2'b00);                         // R5
    wire logic cal_wrap = lock_s2_r & cal_once_r & periodic & (cal_cnt_r >= cal_limit);
    wire logic cal_fire = (lock_s2_r & ~cal_once_r) | cal_wrap;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cal_cnt_r       <= 28'h000_0000;
            cal_once_r      <= 1'b0;
            calibrate_pulse <= 1'b0;
        end else begin
            calibrate_pulse <= cal_fire;                                 // R5
            cal_once_r      <= lock_s2_r & (cal_once_r | cal_fire);
            cal_cnt_r       <= (!lock_s2_r || cal_fire || !periodic) ? 28'h000_0000
                                                                     : cal_cnt_r + 28'h000_0001;
        end
    end

    // ------------------------------------------------------------
    // Interrupts: bit0 lock gained, bit1 lock lost; write one to clear
    // ------------------------------------------------------------
    wire logic [1:0] irq_evt = {lock_d_r & ~lock_s2_r, lock_s2_r & ~lock_d_r};
    wire logic [1:0] irq_clr = (wr_req && hit_ist && pstrb[0]) ? wb[1:0] : 2'b00;
    // Set wins over a clear in the same cycle
    assign irq_st_nxt = (irq_st_r & ~irq_clr) | irq_evt;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_st_r  <= 2'b00;
            irq_msk_r <= 2'b00;
        end else begin
            irq_st_r <= irq_st_nxt;
            if (wr_req && hit_imsk && pstrb[0]) irq_msk_r <= wb[1:0];
        end
    end

    assign irq = |(irq_st_r & irq_msk_r);

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    wire logic [7:0] rd_byte =
        hit_peer  ? peer_r :
        hit_own   ? own_r :
        hit_range ? range_r :
        hit_cal   ? cal_r :
        hit_stat  ? {lock_s2_r, ctrl_r} :                                // R7
        hit_conv  ? conv_r :
        hit_ist   ? {6'b000000, irq_st_r} :
        hit_imsk  ? {6'b000000, irq_msk_r} : 8'h00;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (psel && !penable && !pwrite) begin
            prdata_r <= 32'h0000_0000;
        end else if (rd_req) begin
            prdata_r <= 32'h0000_0000;
        end
    end

    // Read data is combinational within the single-cycle access phase
    assign prdata = rd_req ? {24'h00_0000, rd_byte} : prdata_r;

endmodule
`default_nettype wire

// file: testbench/deserializer_config_registers_checker.sv
// Port-level assertions for the link configuration register bank
`timescale 1ns/1ps
`default_nettype none
module deserializer_config_registers_checker (
    // Clock, reset and APB
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [3:0]  pstrb,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    // Pins and configuration levels
    input wire logic        lock_pin,
    input wire logic        register_write_protect,
    input wire logic [6:0]  peer_serializer_address,
    input wire logic [1:0]  spread_sel,
    input wire logic [1:0]  pixel_clock_range,
    input wire logic        pixel_range_auto,
    input wire logic [1:0]  serial_rate_range,
    input wire logic        serial_rate_auto,
    input wire logic [4:0]  sawtooth_divider,
    input wire logic        divider_autocal,
    input wire logic        calibrate_pulse
);
    // ------------------------------------------------------------
    // Shared timing and sequences
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // Lock must be steady long enough to cross the two-stage synchroniser
    sequence access_s;
        psel && penable;
    endsequence
    sequence lock_steady_s;
        $stable(lock_pin) [*4];
    endsequence

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    AST_PROT_ERR: assert property (access_s ##0 (pwrite && pstrb[0] && register_write_protect
        && paddr <= 8'h7C) |-> pslverr) else $error("Protected write not refused");
    AST_PROT_STICKY: assert property ($rose(register_write_protect) |=>
        register_write_protect [*8]) else $error("Write protect dropped");
    AST_PROT_HOLD: assert property (access_s ##0 (pwrite && register_write_protect
        && paddr == 8'h00) |=> $stable(peer_serializer_address)) else $error("Peer address changed");
    AST_PIX_AUTO: assert property (pixel_range_auto == pixel_clock_range[1])
        else $error("Pixel range auto flag wrong");
    AST_RATE_AUTO: assert property (serial_rate_auto == serial_rate_range[1])
        else $error("Serial rate auto flag wrong");
    AST_DIV_AUTO: assert property (divider_autocal == (sawtooth_divider == 5'h00))
        else $error("Divider autocal flag wrong");
    AST_SPREAD: assert property (spread_sel != 2'b10) else $error("Spread code not folded");
    AST_CAL_PULSE: assert property (calibrate_pulse |=> !calibrate_pulse)
        else $error("Calibration pulse too long");
    AST_LOCK_RD: assert property (lock_steady_s ##0 access_s ##0 (!pwrite && paddr == 8'h10)
        |-> prdata[7] == lock_pin) else $error("Lock flag does not follow pin");
endmodule
bind deserializer_config_registers deserializer_config_registers_checker chk_i (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pstrb, .prdata, .pslverr, .lock_pin,
    .register_write_protect, .peer_serializer_address, .spread_sel, .pixel_clock_range,
    .pixel_range_auto, .serial_rate_range, .serial_rate_auto, .sawtooth_divider,
    .divider_autocal, .calibrate_pulse);
`default_nettype wire

// file: testbench/deserializer_config_registers_tb.sv
// Self-checking bench for the link configuration register bank
`timescale 1ns/1ps
`default_nettype none
module deserializer_config_registers_tb;
    import cfg_regs_pkg::*;
    // ------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [3:0]  pstrb;
    logic        cable, isel, lock, wp, cal, od, bst, slp, li2c, luart, rev, fwd, conv, irq, sra, dac;
    logic [1:0]  spr, pcr, c;
    int          n_mismatch, n_tests, np, n0;

    // Short calibration periods keep the periodic checks brief
    deserializer_config_registers #(.CAL_PERIOD_0(20), .CAL_PERIOD_1(40), .CAL_PERIOD_2(80)) dut (
        .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready,
        .pslverr, .cable_type_input(cable), .interface_select_input(isel), .lock_pin(lock),
        .peer_serializer_address(), .own_device_address(), .register_write_protect(wp),
        .spread_sel(spr), .pixel_clock_range(pcr), .pixel_range_auto(), .serial_rate_range(),
        .serial_rate_auto(sra), .modulation_calibration_interval(), .sawtooth_divider(),
        .divider_autocal(dac), .calibrate_pulse(cal), .output_disable(od),
        .bit_sequence_test_enable(bst), .sleep_mode(slp), .local_i2c_enable(li2c),
        .local_uart_enable(luart), .reverse_channel_enable(rev), .forward_channel_enable(fwd),
        .conversion_method(conv), .irq);

    // ------------------------------------------------------------
    // Clock, pulse counter and tasks
    // ------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end
    always @(posedge pclk) if (cal === 1'b1) np <= np + 1;

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h expected=%h", $time, got, exp);
        end
    endtask
    // One APB transfer; holds the request until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 50);
        if (k >= 50) n_mismatch++;
        rd  = prdata;
        err = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [7:0] a, input logic [7:0] exp);
        apb(1'b0, a, 32'h0000_0000);
        chk(rd, 32'(exp));
    endtask
    // Reset is held 5 cycles; 4 edges let the pin synchronisers settle
    task automatic rst(input logic cb);
        presetn <= 1'b0;
        cable   <= cb;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
        repeat (4) @(posedge pclk);
    endtask
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        {psel, penable, pwrite, cable, isel, lock} = '0;
        {paddr, pwdata, pstrb} = {8'h00, 32'h0000_0000, 4'hF};
        presetn = 1'b0;
        {n_mismatch, n_tests, np} = '0;
        rst(1'b0);
        rdc(8'h00, 8'h80);
        rdc(8'h04, 8'h90);
        rdc(8'h08, 8'h1F);
        rdc(8'h0C, 8'h00);
        rdc(8'h10, 8'h07);
        rdc(8'h14, 8'h00);
        $display("Reset value test done");
        // Every code of the spread, pixel and rate fields; reserved bits stay 01
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            apb(1'b1, 8'h08, 32'({c, c, c, c}));
            rdc(8'h08, {c, 2'b01, c, c});
            chk(32'(spr), 32'((c == 2'b10) ? 2'b00 : c));
            chk(32'(pcr), 32'(c));
            chk(32'(sra), 32'(c[1]));
            apb(1'b1, 8'h0C, 32'({c, 1'b1, 3'b000, c}));
            rdc(8'h0C, {c, 1'b0, 3'b000, c});
            chk(32'(dac), 32'(c == 2'b00));
        end
        $display("Field code test done");
        // Periodic recalibration every 20 cycles, then once-only mode
        apb(1'b1, 8'h0C, 32'h0000_0040);
        n0 = np;
        lock <= 1'b1;
        repeat (100) @(posedge pclk);
        chk(32'(np - n0 >= 4 && np - n0 <= 6), 32'h0000_0001);
        apb(1'b1, 8'h0C, 32'h0000_0000);
        // A pulse launched at the switching edge is still counted two edges on
        repeat (2) @(posedge pclk);
        n0 = np;
        repeat (100) @(posedge pclk);
        chk(32'(np - n0), 32'h0000_0000);
        $display("Calibration test done");
        // Control bits, read-only lock flag and interface types
        apb(1'b1, 8'h10, 32'h0000_00F0);
        rdc(8'h10, 8'hF0);
        chk(32'({od, bst, slp, rev, fwd}), 32'h0000_001C);
        for (int i = 0; i < 4; i++) begin
            apb(1'b1, 8'h10, 32'(i * 4 + 3));
            rdc(8'h10, 8'(8'h83 + i * 4));
            chk(32'({li2c, luart, rev, fwd}), 32'((i == 0) ? 11 : (i == 1) ? 7 : 3));
        end
        isel <= 1'b1;
        apb(1'b1, 8'h10, 32'h0000_0003);
        rdc(8'h10, 8'h83);
        chk(32'({li2c, luart}), 32'h0000_0000);
        lock <= 1'b0;
        rdc(8'h10, 8'h03);
        apb(1'b1, 8'h14, 32'h0000_00FF);
        rdc(8'h14, 8'h80);
        chk(32'(conv), 32'h0000_0001);
        $display("Control test done");
        // Lock edges raise sticky status; mask and write-one-to-clear
        // Lock edges need three clocks to cross the synchroniser and set status
        apb(1'b1, 8'h80, 32'h0000_00FF);
        apb(1'b1, 8'h84, 32'h0000_0001);
        lock <= 1'b1;
        repeat (3) @(posedge pclk);
        rdc(8'h80, 8'h01);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, 8'h80, 32'h0000_0001);
        lock <= 1'b0;
        repeat (3) @(posedge pclk);
        rdc(8'h80, 8'h02);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b1, 8'h84, 32'h0000_0003);
        @(negedge pclk);
        chk(32'(irq), 32'h0000_0001);
        apb(1'b1, 8'h80, 32'h0000_0002);
        @(negedge pclk);
        chk(32'(irq), 32'h0000_0000);
        apb(1'b0, 8'h30, 32'h0000_0000);
        chk(32'(err), 32'h0000_0001);
        $display("Interrupt and unmapped test done");
        // Write protect is sticky and refuses writes to words 0x00 and 0x04 but not to 0x84
        apb(1'b1, 8'h04, 32'h0000_0091);
        rdc(8'h04, 8'h91);
        apb(1'b1, 8'h00, 32'h0000_0022);
        chk(32'(err), 32'h0000_0001);
        rdc(8'h00, 8'h80);
        apb(1'b1, 8'h04, 32'h0000_0090);
        chk(32'({err, wp}), 32'h0000_0003);
        apb(1'b1, 8'h84, 32'h0000_0000);
        chk(32'(err), 32'h0000_0000);
        rst(1'b1);
        rdc(8'h04, 8'h92);
        chk(32'(wp), 32'h0000_0000);
        $display("Protect test done");
        end_of_test();
    end

    // Whole run needs about 400 cycles; this bound only catches hangs
    initial begin
        repeat (20000) @(posedge pclk);
        n_mismatch++;
        end_of_test();
    end
endmodule
`default_nettype wire
